//--- rtl/ebc_engine.sv
// External bus cycle engine: single reads, burst reads, single writes.
// Assumes one request at a time from the core side, held until done.
`timescale 1ns/1ps
`default_nettype none
module ebc_engine (
    input  wire logic             clk_sys_i,
    input  wire logic             reset_n_i,
    input  wire logic             slow_bus_n_i,
    // Core side request
    input  wire logic             req_i,
    input  wire ebc_pkg::ebc_src_t req_src_i,
    input  wire logic             req_write_i,
    input  wire logic             req_burst_i,
    input  wire logic [31:0]      req_addr_i,
    input  wire logic [3:0]       req_be_n_i,
    input  wire logic [31:0]      req_wdata_i,
    input  wire logic             req_unmapped_i,
    output logic                  done_o,
    output logic                  rdata_valid_o,
    output logic [31:0]           rdata_o,
    output logic                  bus_error_o,
    output logic                  nmi_o,
    output logic                  dma_abort_o,
    // Register port
    input  wire logic [3:0]       reg_addr_i,
    input  wire logic [31:0]      reg_wdata_i,
    input  wire logic             reg_wr_i,
    input  wire logic             reg_rd_i,
    output logic [31:0]           reg_rdata_o,
    // External bus
    output logic                  bus_clock_o,
    output logic [31:1]           addr_o,
    output logic [3:0]            byte_lane_en_n_o,
    output logic                  start_strobe_n_o,
    output logic                  final_beat_n_o,
    output logic                  rd_wr_n_o,
    output logic [3:0]            region_select_n_o,
    output logic [31:0]           data_o,
    output logic                  data_oe_n_o,
    input  wire logic [31:0]      data_i,
    input  wire logic             transfer_done_n_i,
    input  wire logic             fault_in_n_i,
    output logic                  fault_out_o,
    output logic                  fault_oe_n_o
);
    import ebc_pkg::*;

    logic       rst_s1_q;
    logic       rst_n;
    logic       tick_q;
    logic       tick;
    ebc_state_t state_q;
    logic [31:0] cs_addr_q;
    logic [31:0] cs_mask_q;
    logic [31:0] cs_wait_q;
    logic        toe_q;
    logic        wflag_q;
    ebc_src_t    src_q;
    logic        write_q;
    logic        burst_q;
    logic        second_q;
    logic        split_q;
    logic [1:0]  beat_q;
    logic [31:0] wdata_q;
    logic [3:0]  sel_hit;
    logic [2:0]  hit_wait;
    logic        hit_narrow;
    logic        ack_seen_q;
    logic        half_hi;
    logic        half_lo;
    logic        refuse;

    ebc_wait_if w ();
    ebc_wait_ctr u_wait (
        .clk_i   (clk_sys_i),
        .rst_n_i (rst_n),
        .w       (w)
    );

    // Reset release through two flops
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    // Bus tick every cycle, or every second cycle in slow mode
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            tick_q      <= 1'b0;
            bus_clock_o <= 1'b0;
        end else begin
            tick_q      <= slow_bus_n_i ? 1'b1 : ~tick_q;
            bus_clock_o <= slow_bus_n_i ? ~bus_clock_o : ~tick_q;
        end
    end
    assign tick = slow_bus_n_i | tick_q;

    // Region decode, one compare per region
    genvar gi;
    generate
        for (gi = 0; gi < EBC_REGIONS; gi++) begin : g_reg
            assign sel_hit[gi] =
                ((req_addr_i[31:24] ^ cs_addr_q[gi*8 +: 8])
                 & cs_mask_q[gi*8 +: 8]) == 8'h00;
        end
    endgenerate

    // Lowest region that hits sets wait code and width
    always_comb begin
        hit_wait   = EBC_WAIT_EXT;
        hit_narrow = 1'b0;
        for (int i = EBC_REGIONS - 1; i >= 0; i--) begin
            if (sel_hit[i]) begin
                hit_wait   = cs_wait_q[i*EBC_WAIT_STRIDE +: 3];
                hit_narrow = cs_wait_q[i*EBC_WAIT_STRIDE
                                       + EBC_NARROW_BIT];
            end
        end
    end
    // Halfword fit tests on lane enables
    assign half_hi = (req_be_n_i[1:0] == 2'h3);
    assign half_lo = (req_be_n_i[3:2] == 2'h3);
    // Unmapped or external-master internal accesses never reach the bus
    assign refuse = req_unmapped_i || (req_src_i == EBC_REQ_EXT &&
                    req_addr_i[31:24] == EBC_INTERNAL_TOP);

    // Registers: region decode, waits, chip configuration
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            cs_addr_q <= EBC_ADDR_RST;
            cs_mask_q <= EBC_MASK_RST;
            cs_wait_q <= EBC_WAIT_RST;
            toe_q     <= 1'b0;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                EBC_OFS_ADDR:  cs_addr_q <= reg_wdata_i;
                EBC_OFS_MASK:  cs_mask_q <= reg_wdata_i;
                EBC_OFS_WAIT:  cs_wait_q <= reg_wdata_i;
                EBC_OFS_CCONF: toe_q     <= reg_wdata_i[EBC_CC_TOE];
                default: ;
            endcase
        end
    end

    // Read data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_o <= 32'h0000_0000;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                EBC_OFS_ADDR:  reg_rdata_o <= cs_addr_q;
                EBC_OFS_MASK:  reg_rdata_o <= cs_mask_q;
                EBC_OFS_WAIT:  reg_rdata_o <= cs_wait_q;
                EBC_OFS_CCONF: reg_rdata_o <= {30'h0, wflag_q, toe_q};
                default:       reg_rdata_o <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata_o <= 32'h0000_0000;
        end
    end

    // Counter hookup
    assign w.step     = tick;
    assign w.ack_ext  = ~transfer_done_n_i;
    assign w.timeout_enable      = toe_q;
    assign w.load     = tick && (state_q == EBC_START ||
                        (state_q == EBC_DATA && burst_q));

    // Cycle sequencer
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            state_q  <= EBC_IDLE;
            beat_q   <= 2'h0;
            second_q <= 1'b0;
            split_q  <= 1'b0;
        end else if (tick) begin
            case (state_q)
                EBC_IDLE: begin
                    second_q <= 1'b0;
                    beat_q   <= 2'h0;
                    if (req_i && !done_o) begin
                        if (refuse) begin
                            state_q <= EBC_FAULT;
                        end else begin
                            split_q <= hit_narrow && !req_burst_i &&
                                       !half_hi && !half_lo;
                            state_q <= EBC_START;
                        end
                    end
                end
                EBC_START: begin
                    state_q <= EBC_WAIT;
                end
                EBC_WAIT, EBC_DATA: begin
                    if (!fault_in_n_i || w.timeout) begin
                        state_q <= EBC_FAULT;
                    end else if (w.ack) begin
                        if (burst_q) begin
                            beat_q  <= beat_q + 2'h1;
                            state_q <= (beat_q == EBC_BURST_WORDS) ?
                                       EBC_END : EBC_DATA;
                        end else begin
                            state_q <= EBC_END;
                        end
                    end else begin
                        state_q <= EBC_WAIT;
                    end
                end
                EBC_END: begin
                    if (split_q && !second_q) begin
                        second_q <= 1'b1;
                        state_q  <= EBC_START;
                    end else begin
                        state_q <= EBC_ACKOUT;
                    end
                end
                EBC_FAULT: state_q <= EBC_ACKOUT;
                EBC_ACKOUT: state_q <= EBC_IDLE;
                default: state_q <= EBC_IDLE;
            endcase
        end
    end

    // Latch request attributes at start; hold them through the op
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            src_q   <= EBC_REQ_CPU;
            write_q <= 1'b0;
            burst_q <= 1'b0;
            wdata_q <= 32'h0000_0000;
            w.wait_sel <= EBC_WAIT_EXT;
        end else if (tick && state_q == EBC_IDLE && req_i) begin
            src_q      <= req_src_i;
            write_q    <= req_write_i;
            burst_q    <= req_burst_i && !req_write_i;
            wdata_q    <= req_wdata_i;
            w.wait_sel <= hit_wait;
        end
    end

    // Bus address, lanes, select, direction
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            addr_o            <= 31'h0000_0000;
            byte_lane_en_n_o  <= EBC_BE_NONE;
            region_select_n_o <= 4'hF;
            rd_wr_n_o         <= 1'b1;
        end else if (tick) begin
            if (state_q == EBC_IDLE && req_i && !done_o && !refuse) begin
                addr_o            <= req_addr_i[31:1];
                region_select_n_o <= ~sel_hit;
                rd_wr_n_o         <= ~req_write_i;
                if (req_burst_i && !req_write_i) begin
                    byte_lane_en_n_o <= 4'h0;
                end else if (hit_narrow && half_lo) begin
                    byte_lane_en_n_o <= {2'h3, req_be_n_i[1:0]};
                end else if (hit_narrow) begin
                    byte_lane_en_n_o <= {2'h3, req_be_n_i[3:2]};
                end else begin
                    byte_lane_en_n_o <= req_be_n_i;
                end
            end else if (state_q == EBC_END && split_q && !second_q) begin
                addr_o[1]        <= 1'b1;
                byte_lane_en_n_o <= {2'h3, req_be_n_i[1:0]};
            end else if ((state_q == EBC_WAIT || state_q == EBC_DATA) &&
                         burst_q && w.ack) begin
                addr_o <= addr_o + 31'h2;
            end else if (state_q == EBC_ACKOUT) begin
                region_select_n_o <= 4'hF;
                byte_lane_en_n_o  <= EBC_BE_NONE;
                rd_wr_n_o         <= 1'b1;
            end
        end
    end

    // Start strobe and final-beat marker
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            start_strobe_n_o <= 1'b1;
            final_beat_n_o   <= 1'b1;
        end else if (tick) begin
            start_strobe_n_o <= 1'b1;
            if ((state_q == EBC_IDLE && req_i && !done_o &&
                 !refuse) ||
                (state_q == EBC_END && split_q && !second_q)) begin
                start_strobe_n_o <= 1'b0;
                final_beat_n_o   <= req_burst_i && !req_write_i &&
                                    state_q == EBC_IDLE;
            end else if (state_q == EBC_WAIT || state_q == EBC_DATA) begin
                if (!fault_in_n_i || w.timeout) begin
                    final_beat_n_o <= 1'b1;
                end else if (w.ack) begin
                    final_beat_n_o <= !(burst_q &&
                        beat_q == EBC_BURST_WORDS - 2'h1);
                end
            end
        end
    end

    // Write data drive; released the cycle after final_beat_n_o rises, but held between the two halves of a split write
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            data_o      <= 32'h0000_0000;
            data_oe_n_o <= 1'b1;
        end else if (tick) begin
            if (state_q == EBC_IDLE && req_i && req_write_i && !done_o &&
                !refuse) begin
                data_oe_n_o <= 1'b0;
                data_o <= hit_narrow && !half_lo ?
                          {16'h0000, req_wdata_i[31:16]} : req_wdata_i;
            end else if (state_q == EBC_END && split_q && !second_q) begin
                data_o <= {16'h0000, wdata_q[15:0]};
            end else if (state_q == EBC_END || state_q == EBC_FAULT) begin
                data_oe_n_o <= 1'b1;
            end
        end
    end

    // Read capture and completion reporting
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_o       <= 32'h0000_0000;
            rdata_valid_o <= 1'b0;
            done_o        <= 1'b0;
            bus_error_o   <= 1'b0;
            nmi_o         <= 1'b0;
            dma_abort_o   <= 1'b0;
            fault_out_o   <= 1'b1;
            fault_oe_n_o  <= 1'b1;
            wflag_q       <= 1'b0;
            ack_seen_q    <= 1'b0;
        end else begin
            rdata_valid_o <= 1'b0;
            done_o        <= 1'b0;
            bus_error_o   <= 1'b0;
            nmi_o         <= 1'b0;
            dma_abort_o   <= 1'b0;
            fault_oe_n_o  <= 1'b1;
            if (tick) begin
                ack_seen_q <= (state_q == EBC_WAIT || state_q == EBC_DATA)
                              && w.ack && fault_in_n_i && !w.timeout;
            end
            if (tick && ack_seen_q && !write_q) begin
                rdata_valid_o <= !(split_q && !second_q);
                if (split_q && !second_q) begin
                    rdata_o[31:16] <= data_i[15:0];
                end else if (split_q) begin
                    rdata_o[15:0] <= data_i[15:0];
                end else begin
                    rdata_o <= data_i;
                end
            end
            if (tick && state_q == EBC_FAULT) begin
                if (src_q == EBC_REQ_EXT) begin
                    fault_oe_n_o <= 1'b0;
                    fault_out_o  <= 1'b0;
                end else if (src_q == EBC_REQ_DMA) begin
                    dma_abort_o <= 1'b1;
                end else if (write_q) begin
                    nmi_o   <= 1'b1;
                    wflag_q <= 1'b1;
                end else begin
                    bus_error_o <= 1'b1;
                end
            end else if (reg_wr_i && reg_addr_i == EBC_OFS_CCONF &&
                         !reg_wdata_i[EBC_CC_WFLAG]) begin
                wflag_q <= 1'b0;
            end
            if (tick && state_q == EBC_ACKOUT) begin
                done_o <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

//--- rtl/ebc_pkg.sv
// Package for the external bus cycle engine: constants and types.
// Assumes a single 100 MHz core clock; the bus clock is derived from it.
package ebc_pkg;
    localparam int          EBC_REGIONS      = 4;
    localparam int          EBC_TIMEOUT_CYC  = 256;
    localparam logic [8:0]  EBC_TIMEOUT_LIM  = 9'h100;
    localparam logic [2:0]  EBC_WAIT_EXT     = 3'h7;
    localparam logic [1:0]  EBC_BURST_WORDS  = 2'h3;
    localparam logic [3:0]  EBC_BE_NONE      = 4'hF;
    localparam logic [3:0]  EBC_BE_LOW_HALF  = 4'hC;
    localparam logic [7:0]  EBC_INTERNAL_TOP = 8'hFF;
    // Register offsets of the region and chip configuration registers
    localparam logic [3:0]  EBC_OFS_ADDR     = 4'h0;
    localparam logic [3:0]  EBC_OFS_MASK     = 4'h4;
    localparam logic [3:0]  EBC_OFS_WAIT     = 4'h8;
    localparam logic [3:0]  EBC_OFS_CCONF    = 4'hC;
    // Reset values
    localparam logic [31:0] EBC_ADDR_RST     = 32'h0000_0000;
    localparam logic [31:0] EBC_MASK_RST     = 32'h0000_0000;
    localparam logic [31:0] EBC_WAIT_RST     = 32'h7777_7777;
    // Bit positions in chip_config_reg
    localparam int          EBC_CC_TOE       = 0;
    localparam int          EBC_CC_WFLAG     = 1;
    // Fields in the wait register, one byte per region
    localparam int          EBC_WAIT_STRIDE  = 8;
    localparam int          EBC_NARROW_BIT   = 3;

    typedef enum logic [6:0] {
        EBC_IDLE   = 7'b0000001,
        EBC_START  = 7'b0000010,
        EBC_WAIT   = 7'b0000100,
        EBC_DATA   = 7'b0001000,
        EBC_END    = 7'b0010000,
        EBC_FAULT  = 7'b0100000,
        EBC_ACKOUT = 7'b1000000
    } ebc_state_t;

    typedef enum logic [1:0] {
        EBC_REQ_CPU = 2'h0,
        EBC_REQ_DMA = 2'h1,
        EBC_REQ_EXT = 2'h2
    } ebc_src_t;
endpackage

//--- rtl/ebc_wait_ctr.sv
// Wait and timeout counter for one bus beat.
// Assumes load and step come from the engine on the core clock.
`timescale 1ns/1ps
`default_nettype none
module ebc_wait_ctr (
    input  wire logic   clk_i,
    input  wire logic   rst_n_i,
    ebc_wait_if.counter w
);
    import ebc_pkg::*;
    logic [2:0] wcnt_q;
    logic [8:0] tcnt_q;

    // Ack from programmed count or external acknowledge
    always_comb begin
        if (w.wait_sel == EBC_WAIT_EXT) begin
            w.ack = w.ack_ext;
        end else begin
            w.ack = (wcnt_q == w.wait_sel);
        end
    end
    assign w.timeout = w.timeout_enable && (tcnt_q == EBC_TIMEOUT_LIM);

    // Count wait cycles per beat, same count every beat
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wcnt_q <= 3'h0;
        end else if (w.load) begin
            wcnt_q <= 3'h0;
        end else if (w.step && wcnt_q != 3'h7) begin
            wcnt_q <= wcnt_q + 3'h1;
        end
    end

    // Timeout counter restarts on each beat
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tcnt_q <= 9'h000;
        end else if (w.load) begin
            tcnt_q <= 9'h001;
        end else if (w.step && tcnt_q != EBC_TIMEOUT_LIM) begin
            tcnt_q <= tcnt_q + 9'h001;
        end
    end
endmodule
`default_nettype wire

//--- rtl/ebc_wait_if.sv
// Interface between the cycle engine and its wait/timeout counter.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
`default_nettype none
interface ebc_wait_if;
    logic       load;      // Restart counting at a beat start
    logic [2:0] wait_sel;  // Wait code of the region
    logic       step;      // Bus clock tick
    logic       ack_ext;   // External acknowledge sampled low
    logic       ack;       // Beat acknowledged
    logic       timeout;   // 256 bus clocks without acknowledge
    logic       timeout_enable;       // Timeout checking on
    modport engine (output load, wait_sel, step, ack_ext, timeout_enable,
                    input ack, timeout);
    modport counter (input load, wait_sel, step, ack_ext, timeout_enable,
                     output ack, timeout);
endinterface
`default_nettype wire

//--- verif/ebc_engine_chk.sv
// Pin checker for the external bus cycle engine.
// Assumes full-speed timing while slow_bus_n_i is high.
`timescale 1ns/1ps
`default_nettype none
module ebc_engine_chk (
    input wire logic        clk_sys_i,
    input wire logic        reset_n_i,
    input wire logic        slow_bus_n_i,
    input wire logic [31:1] addr_o,
    input wire logic [3:0]  byte_lane_en_n_o,
    input wire logic        start_strobe_n_o,
    input wire logic        final_beat_n_o,
    input wire logic        rd_wr_n_o,
    input wire logic [3:0]  region_select_n_o,
    input wire logic        data_oe_n_o,
    input wire logic        transfer_done_n_i,
    input wire logic        fault_in_n_i,
    input wire logic        bus_error_o,
    input wire logic        nmi_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    // Start cycle shape
    property p_one; slow_bus_n_i && $fell(start_strobe_n_o) |=>
        start_strobe_n_o; endproperty
    a_one: assert property (p_one) else $error("strobe too long");
    property p_brst; $fell(start_strobe_n_o) && final_beat_n_o |->
        byte_lane_en_n_o == 4'h0; endproperty
    a_brst: assert property (p_brst) else $error("burst lanes");
    property p_wsgl; $fell(start_strobe_n_o) && !rd_wr_n_o |->
        !final_beat_n_o && !data_oe_n_o; endproperty
    a_wsgl: assert property (p_wsgl) else $error("write start");
    // Data release and holding through waits
    property p_wrel; $rose(final_beat_n_o) && !data_oe_n_o |=>
        data_oe_n_o; endproperty
    a_wrel: assert property (p_wrel) else $error("data held");
    property p_hold; !final_beat_n_o ##1 !final_beat_n_o |->
        $stable(addr_o) && $stable(region_select_n_o) &&
        $stable(rd_wr_n_o) && $stable(byte_lane_en_n_o); endproperty
    a_hold: assert property (p_hold) else $error("bus moved");
    // Acknowledge and fault reactions
    property p_ack; slow_bus_n_i && !final_beat_n_o && start_strobe_n_o &&
        !transfer_done_n_i |-> ##[0:1] final_beat_n_o; endproperty
    a_ack: assert property (p_ack) else $error("final late");
    property p_rflt; !fault_in_n_i && !final_beat_n_o && start_strobe_n_o
        && rd_wr_n_o |-> ##[1:3] bus_error_o; endproperty
    a_rflt: assert property (p_rflt) else $error("no bus error");
    property p_wflt; !fault_in_n_i && !final_beat_n_o && start_strobe_n_o
        && !rd_wr_n_o |-> ##[1:3] nmi_o; endproperty
    a_wflt: assert property (p_wflt) else $error("no nmi");
    c_brst: cover property ($fell(start_strobe_n_o) && final_beat_n_o);
    c_err: cover property (bus_error_o);
    c_nmi: cover property (nmi_o);
endmodule
bind ebc_engine ebc_engine_chk u_chk (.*);
`default_nettype wire

//--- verif/ebc_engine_test.sv
// Bench for the external bus cycle engine and far-side model.
// Assumes full-speed bus; reset held three cycles.
`timescale 1ns/1ps
`default_nettype none
module ebc_engine_test;
    import ebc_pkg::*;
    logic clk_sys_i, reset_n_i = 0, req = 0, wr = 0, bst = 0, unm = 0;
    logic rwr = 0, rrd = 0, ext = 1, flt = 1, done, rv, be_o, nmi, dab, bck;
    logic st_n, fin_n, rw_n, oe_n, ack_n, fo, fo_n;
    logic [31:0] ad = 0, wd = 0, rwd = 0, rdat, rrdat, d_i, dat, wds;
    logic [3:0] be = 0, ra = 0, waits = 4'h2, lanes, sel_n;
    logic [31:1] a_o;
    ebc_src_t src = EBC_REQ_CPU;
    wire flt_w = flt & (fo_n | fo);
    int n_fail, check_count, cyc, n_st, t_st, t_rv, t_er, t_nm, t0, ns;
    logic [31:0] rq[$];
    ebc_engine uut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .slow_bus_n_i(1'b1), .req_i(req), .req_src_i(src), .req_write_i(wr),
        .req_burst_i(bst), .req_addr_i(ad), .req_be_n_i(be), .req_wdata_i(wd),
        .req_unmapped_i(unm), .done_o(done), .rdata_valid_o(rv),
        .rdata_o(rdat), .bus_error_o(be_o), .nmi_o(nmi), .dma_abort_o(dab),
        .reg_addr_i(ra), .reg_wdata_i(rwd), .reg_wr_i(rwr), .reg_rd_i(rrd),
        .reg_rdata_o(rrdat), .bus_clock_o(bck), .addr_o(a_o),
        .byte_lane_en_n_o(lanes), .start_strobe_n_o(st_n),
        .final_beat_n_o(fin_n), .rd_wr_n_o(rw_n), .region_select_n_o(sel_n),
        .data_o(dat), .data_oe_n_o(oe_n), .data_i(d_i),
        .transfer_done_n_i(ack_n), .fault_in_n_i(flt_w), .fault_out_o(fo),
        .fault_oe_n_o(fo_n));
    ebc_mem_model mem (.clk_i(clk_sys_i), .strobe_n_i(st_n),
        .final_n_i(fin_n), .sel_n_i(sel_n), .addr_i(a_o), .ext_i(ext),
        .waits_i(waits), .ack_n_o(ack_n), .data_o(d_i));
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    // Time-stamp strobes, read words and error pulses
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (!st_n) begin
            n_st <= n_st + 1;
            t_st <= cyc;
            wds <= dat;
        end
        if (rv && rq.size() == 0) t_rv <= cyc;
        if (rv) rq.push_back(rdat);
        if (be_o) t_er <= cyc;
        if (nmi || !fo_n) t_nm <= cyc;
    end
    function automatic logic [31:0] fx(logic [31:0] a);
        return {a[15:0], ~a[15:0]};
    endfunction
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        check_count++;
        if (e !== g) begin
            n_fail++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic test_done;
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic rg(logic w, logic [3:0] a, logic [31:0] d);
        @(posedge clk_sys_i);
        {ra, rwd, rwr, rrd} <= {a, d, w, !w};
        @(posedge clk_sys_i);
        {rwr, rrd} <= 2'b00;
        @(posedge clk_sys_i);
        if (!w) chk("reg", d, rrdat);
    endtask
    // Hold one request until answered; fa picks a fault cycle
    task automatic op(logic w, logic b, logic [31:0] a, logic [3:0] e, int fa);
        int s0;
        s0 = n_st;
        rq.delete();
        @(posedge clk_sys_i);
        t0 = cyc;
        {wr, bst, ad, be, wd, req} <= {w, b, a, e, ~a, 1'b1};
        for (int k = 0; k <= 400; k++) begin
            @(posedge clk_sys_i);
            flt <= (k != fa);
            if (k == 400) begin
                n_fail++;
                test_done;
            end
            if (done || be_o || nmi || !fo_n) break;
        end
        req <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        ns = n_st - s0;
    endtask
    task automatic t_reads;
        logic [31:0] a;
        rg(0, EBC_OFS_WAIT, EBC_WAIT_RST);
        for (int w = 0; w < 8; w++) begin
            a = 32'h0000_0100 << w;
            ext <= (w == 7);
            rg(1, EBC_OFS_WAIT, 32'(w));
            op(0, 0, a, 4'h0, -1);
            chk("latency", (w == 7) ? 5 : 3 + w, t_rv - t_st);
            chk("rdata", fx(a), rq[0]);
        end
        ext <= 1'b0;
        rg(1, EBC_OFS_WAIT, 32'h8);
        op(0, 0, a, 4'h0, -1);
        chk("halves", 2, ns);
        chk("narrow", {~a[15:0], ~(a[15:0] + 16'h2)}, rq[0]);
        op(0, 0, a, EBC_BE_LOW_HALF, -1);
        chk("one half", 1, ns);
        $display("reads done");
    endtask
    task automatic t_bw;
        logic [31:0] a;
        a = 32'h0000_2000;
        rg(1, EBC_OFS_WAIT, 32'h7);
        {ext, waits} <= {1'b1, 4'h1};
        op(0, 1, a, 4'h0, -1);
        chk("beats", 4, rq.size());
        chk("first beat", 4, t_rv - t_st);
        for (int i = 0; i < 4; i++) chk("burst", fx(a + 32'(4 * i)), rq[i]);
        op(1, 1, a, 4'h0, -1);
        chk("write ops", 1, ns);
        chk("wdata", ~a, wds);
        $display("burst and write done");
    endtask
    task automatic t_flt;
        waits <= 4'hF;
        op(0, 0, 32'h40, 4'h0, 5);
        chk("read fault", 1, t_er > t0);
        op(1, 0, 32'h40, 4'h0, 5);
        chk("write fault", 1, t_nm > t0);
        rg(0, EBC_OFS_CCONF, 32'h2);
        rg(1, EBC_OFS_CCONF, 32'h1);
        op(0, 0, 32'h40, 4'h0, -1);
        chk("timeout", 1, (t_er - t_st) inside {[256:258]});
        unm <= 1'b1;
        op(0, 0, 32'h40, 4'h0, -1);
        chk("unmapped", 1, t_er > t0 && ns == 0);
        unm <= 1'b0;
        src <= EBC_REQ_EXT;
        op(0, 0, 32'hFF00_0000, 4'h0, -1);
        chk("ext master", 1, t_nm > t0 && ns == 0);
        $display("faults done");
    endtask
    initial begin
        repeat (3) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        t_reads;
        t_bw;
        t_flt;
        test_done;
    end
endmodule
`default_nettype wire

//--- verif/ebc_mem_model.sv
// Far-side memory: answers beats after a set number of waits.
// Assumes a pull-up on the acknowledge line.
`timescale 1ns/1ps
`default_nettype none
module ebc_mem_model (
    input  wire logic        clk_i,
    input  wire logic        strobe_n_i,
    input  wire logic        final_n_i,
    input  wire logic [3:0]  sel_n_i,
    input  wire logic [31:1] addr_i,
    input  wire logic        ext_i,
    input  wire logic [3:0]  waits_i,
    output logic             ack_n_o,
    output logic [31:0]      data_o
);
    logic [3:0]  cnt_q;
    logic [2:0]  left_q;
    logic        busy_q = 1'b0;
    logic [31:0] rd_q;
    wire  [15:0] a = {addr_i[15:1], 1'b0};
    // Data of the address seen one edge ago, so a burst address step
    // does not disturb the word being captured; inverted once deselected
    assign data_o = rd_q ^ {32{&sel_n_i}};
    // Drive acknowledge only for external regions; F never answers
    assign ack_n_o = !(ext_i && busy_q && cnt_q == waits_i
                       && waits_i != 4'hF);
    // Same wait count for every beat
    always @(posedge clk_i) begin
        rd_q <= {a, ~a};
        if (!strobe_n_i) begin
            busy_q <= 1'b1;
            cnt_q  <= 4'h0;
            left_q <= final_n_i ? 3'h4 : 3'h1;
        end else if (!ack_n_o) begin
            cnt_q  <= 4'h0;
            left_q <= left_q - 3'h1;
            busy_q <= left_q != 3'h1;
        end else if (busy_q) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule
`default_nettype wire
